// File: hdl/ils_alu.v
// Notes on behaviour
// - Flagged add, add-carry, subtract, subtract-carry, reverse subtract update N Z C V.
// - AND, exclusive_or and inclusive_or combine first source with flexible second source.
// - bit_clear_op ANDs first source with inverted flexible second source.
// - or_with_complement ORs first source with inverted flexible second source.
// - Flagged logic and copies: N Z from result, C from shifter, V kept.
// - Register shift amount uses only its low eight bits, 0 to 255.
// - Immediate shift ranges: arithmetic right 1-32, left 0-31, logical right 1-32, rotate 1-31; the code passes any immediate 0 to 63 unchanged.
// - extended_rotate moves source bits one place toward bit 0.
// - Shifts write the destination and never alter the source register.
// - Flagged shifts set N Z, carry is last bit out, kept on zero shift.
// - leading_zero_count counts zeros from bit 31: 32 for zero, 0 if bit 31 set.
// - leading_zero_count leaves every flag unchanged.
// - compare_op subtracts, sets flags like a flagged difference, writes nothing.
// - compare_negated adds, sets flags like a flagged addition, drops the sum.
// - copy_op places the flexible second source unchanged in the destination.
// - inverted_copy writes the complement of the flexible second source.
// - copy with register-held shift equals the standalone shift with same operands.
// - Wide constant copy loads a 16-bit unsigned constant 0 to 65535.
// - Copy into program_counter ignores bit 0 and branches with bit 0 cleared.
//
// Design decisions made here: the address map and the Avalon-MM register port.
`include "ils_regs.vh"
`default_nettype none

module ils_alu #(
	parameter WIDTH = 32
) (
	input wire i_clk, // core clock, 50 MHz
	input wire i_rstn, // asynchronous reset, active low
	input wire [4:0] i_avs_address, // byte address
	input wire i_avs_read, // read request
	input wire i_avs_write, // write request
	input wire [31:0] i_avs_writedata, // write data
	input wire [3:0] i_avs_byteenable, // write byte lanes
	output reg [31:0] o_avs_readdata, // read data
	output wire o_avs_waitrequest, // stall while high
	output reg o_branch_valid, // one-cycle branch pulse
	output reg [31:0] o_branch_addr // branch target
);

	localparam ST_IDLE = 2'b01;
	localparam ST_ACK = 2'b10;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [WIDTH-1:0] first_source_reg_ff;
	reg [WIDTH-1:0] shifted_source_reg_ff;
	reg [WIDTH-1:0] shift_amount_reg_ff;
	reg [`ILS_CTRL_WIDTH-1:0] ctrl_ff;
	reg [3:0] flags_ff;
	reg [WIDTH-1:0] result_ff;
	reg [WIDTH-1:0] program_counter_ff;
	reg go_ff;
	reg wrote_ff;
	reg branch_ff;

	reg [3:0] nxt_flags;
	reg [WIDTH-1:0] nxt_result;
	reg nxt_wrote;
	reg nxt_branch;
	reg [31:0] rd_mux;

	wire req = i_avs_read | i_avs_write;
	wire take = (state_ff == ST_ACK);
	wire wr_take = take & i_avs_write;
	wire [2:0] widx = i_avs_address[4:2];

	wire [4:0] op = ctrl_ff[`ILS_CTRL_OP_MSB:`ILS_CTRL_OP_LSB];
	wire setf = ctrl_ff[`ILS_CTRL_SETF];
	wire [2:0] sh_type = ctrl_ff[`ILS_CTRL_SHT_MSB:`ILS_CTRL_SHT_LSB];
	wire sh_from_reg = ctrl_ff[`ILS_CTRL_SHREG];
	wire [5:0] sh_imm = ctrl_ff[`ILS_CTRL_IMM_MSB:`ILS_CTRL_IMM_LSB];
	wire dest_pc = ctrl_ff[`ILS_CTRL_DPC];

	// Register amounts keep only the low byte; immediates pass 0..63 unchanged.
	wire [7:0] sh_amount = sh_from_reg ? shift_amount_reg_ff[7:0]
		: {2'b00, sh_imm};

	wire [WIDTH-1:0] flex;
	wire flex_carry;
	wire [5:0] lz_count;

	ils_shifter #(
		.WIDTH(WIDTH)
	) u_shifter (
		.i_value(shifted_source_reg_ff),
		.i_type(sh_type),
		.i_amount(sh_amount),
		.i_carry(flags_ff[`ILS_FLG_C]),
		.o_result(flex),
		.o_carry(flex_carry)
	);

	ils_lzc #(
		.WIDTH(WIDTH)
	) u_lzc (
		.i_value(shifted_source_reg_ff),
		.o_count(lz_count)
	);

	// Returns {C, V, sum} for x + y + ci, so the top pair lands on flag bits 1 and 0.
	function [WIDTH+1:0] add_vc;
		input [WIDTH-1:0] x;
		input [WIDTH-1:0] y;
		input ci;
		reg [WIDTH:0] s;
		begin
			s = {1'b0, x} + {1'b0, y} + {{WIDTH{1'b0}}, ci};
			add_vc = {s[WIDTH], (x[WIDTH-1] == y[WIDTH-1]) && (s[WIDTH-1] != x[WIDTH-1]),
				s[WIDTH-1:0]};
		end
	endfunction

	// Byte-lane merge of a write into an existing word.
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] be;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1)
			begin
				if (be[k])
				begin
					merge[8*k +: 8] = data[8*k +: 8];
				end
			end
		end
	endfunction

	wire [WIDTH+1:0] arith_add = add_vc(first_source_reg_ff, flex, 1'b0);
	wire [WIDTH+1:0] arith_adc = add_vc(first_source_reg_ff, flex, flags_ff[`ILS_FLG_C]);
	wire [WIDTH+1:0] arith_sub = add_vc(first_source_reg_ff, ~flex, 1'b1);
	wire [WIDTH+1:0] arith_sbc = add_vc(first_source_reg_ff, ~flex, flags_ff[`ILS_FLG_C]);
	wire [WIDTH+1:0] arith_rsb = add_vc(flex, ~first_source_reg_ff, 1'b1);
	wire [31:0] ctrl_merged = merge({{(32-`ILS_CTRL_WIDTH){1'b0}}, ctrl_ff},
		i_avs_writedata, i_avs_byteenable);

	// Bus handshake: one stall cycle per access, two while an operation runs.
	always @*
	begin
		case (state_ff)
			ST_IDLE:
			begin
				nxt_state = (req && !go_ff) ? ST_ACK : ST_IDLE;
			end
			ST_ACK:
			begin
				nxt_state = ST_IDLE;
			end
			default:
			begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	assign o_avs_waitrequest = req & ~take;

	always @*
	begin
		case (widx)
			3'h0: rd_mux = first_source_reg_ff;
			3'h1: rd_mux = shifted_source_reg_ff;
			3'h2: rd_mux = shift_amount_reg_ff;
			3'h3: rd_mux = {{(32-`ILS_CTRL_WIDTH){1'b0}}, ctrl_ff};
			3'h4: rd_mux = {28'h000_0000, flags_ff};
			3'h5: rd_mux = result_ff;
			3'h6: rd_mux = program_counter_ff;
			3'h7: rd_mux = {29'h0000_0000, branch_ff, wrote_ff, go_ff};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Operation execute: results and flags for the cycle after a control write.
	always @*
	begin
		nxt_flags = flags_ff;
		nxt_result = result_ff;
		nxt_wrote = 1'b0;
		nxt_branch = 1'b0;
		case (op)
			`ILS_OP_ADD, `ILS_OP_ADC, `ILS_OP_SUB, `ILS_OP_SBC, `ILS_OP_RSB:
			begin
				nxt_wrote = 1'b1;
				case (op)
					`ILS_OP_ADD: nxt_result = arith_add[WIDTH-1:0];
					`ILS_OP_ADC: nxt_result = arith_adc[WIDTH-1:0];
					`ILS_OP_SUB: nxt_result = arith_sub[WIDTH-1:0];
					`ILS_OP_SBC: nxt_result = arith_sbc[WIDTH-1:0];
					default: nxt_result = arith_rsb[WIDTH-1:0];
				endcase
				if (setf)
				begin
					nxt_flags[`ILS_FLG_N] = nxt_result[WIDTH-1];
					nxt_flags[`ILS_FLG_Z] = (nxt_result == {WIDTH{1'b0}});
					case (op)
						`ILS_OP_ADD: nxt_flags[1:0] = arith_add[WIDTH+1:WIDTH];
						`ILS_OP_ADC: nxt_flags[1:0] = arith_adc[WIDTH+1:WIDTH];
						`ILS_OP_SUB: nxt_flags[1:0] = arith_sub[WIDTH+1:WIDTH];
						`ILS_OP_SBC: nxt_flags[1:0] = arith_sbc[WIDTH+1:WIDTH];
						default: nxt_flags[1:0] = arith_rsb[WIDTH+1:WIDTH];
					endcase
				end
			end
			`ILS_OP_AND, `ILS_OP_XOR, `ILS_OP_IOR, `ILS_OP_BCLR, `ILS_OP_ORNOT,
			`ILS_OP_COPY, `ILS_OP_NCOPY:
			begin
				nxt_wrote = 1'b1;
				case (op)
					`ILS_OP_AND: nxt_result = first_source_reg_ff & flex;
					`ILS_OP_XOR: nxt_result = first_source_reg_ff ^ flex;
					`ILS_OP_IOR: nxt_result = first_source_reg_ff | flex;
					`ILS_OP_BCLR: nxt_result = first_source_reg_ff & ~flex;
					`ILS_OP_ORNOT: nxt_result = first_source_reg_ff | ~flex;
					`ILS_OP_NCOPY: nxt_result = ~flex;
					// A copy through the shifter is the standalone shift itself.
					default: nxt_result = flex;
				endcase
				// Flag updates on a program counter copy are not allowed by the issuer.
				if (setf && !(op == `ILS_OP_COPY && dest_pc))
				begin
					nxt_flags[`ILS_FLG_N] = nxt_result[WIDTH-1];
					nxt_flags[`ILS_FLG_Z] = (nxt_result == {WIDTH{1'b0}});
					// The shifter returns the old carry for a zero amount, except extended_rotate, which returns source bit 0.
					nxt_flags[`ILS_FLG_C] = flex_carry;
				end
				if (op == `ILS_OP_COPY && dest_pc)
				begin
					// A branch leaves the result register as it was.
					nxt_result = result_ff;
					nxt_wrote = 1'b0;
					nxt_branch = 1'b1;
				end
			end
			`ILS_OP_COMPARE:
			begin
				nxt_flags[`ILS_FLG_N] = arith_sub[WIDTH-1];
				nxt_flags[`ILS_FLG_Z] = (arith_sub[WIDTH-1:0] == {WIDTH{1'b0}});
				nxt_flags[1:0] = arith_sub[WIDTH+1:WIDTH];
			end
			`ILS_OP_NCOMPARE:
			begin
				nxt_flags[`ILS_FLG_N] = arith_add[WIDTH-1];
				nxt_flags[`ILS_FLG_Z] = (arith_add[WIDTH-1:0] == {WIDTH{1'b0}});
				nxt_flags[1:0] = arith_add[WIDTH+1:WIDTH];
			end
			`ILS_OP_LZC:
			begin
				nxt_wrote = 1'b1;
				nxt_result = {{(WIDTH-6){1'b0}}, lz_count};
			end
			`ILS_OP_WIDE:
			begin
				nxt_wrote = 1'b1;
				nxt_result = {{(WIDTH-16){1'b0}}, shifted_source_reg_ff[15:0]};
			end
			default:
			begin
				nxt_wrote = 1'b0;
			end
		endcase
	end

	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_ff <= ST_IDLE;
			o_avs_readdata <= `ILS_RST_WORD;
			first_source_reg_ff <= `ILS_RST_WORD;
			shifted_source_reg_ff <= `ILS_RST_WORD;
			shift_amount_reg_ff <= `ILS_RST_WORD;
			ctrl_ff <= `ILS_RST_CTRL;
			go_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			if (state_ff == ST_IDLE && nxt_state == ST_ACK && i_avs_read)
			begin
				o_avs_readdata <= rd_mux;
			end
			go_ff <= wr_take && (i_avs_address == `ILS_OFF_CTRL);
			if (wr_take)
			begin
				case (i_avs_address)
					`ILS_OFF_OPA:
						first_source_reg_ff <= merge(first_source_reg_ff, i_avs_writedata,
							i_avs_byteenable);
					`ILS_OFF_OPB:
						shifted_source_reg_ff <= merge(shifted_source_reg_ff, i_avs_writedata,
							i_avs_byteenable);
					`ILS_OFF_SHAMT:
						shift_amount_reg_ff <= merge(shift_amount_reg_ff, i_avs_writedata,
							i_avs_byteenable);
					`ILS_OFF_CTRL:
						ctrl_ff <= ctrl_merged[`ILS_CTRL_WIDTH-1:0];
					default:
						ctrl_ff <= ctrl_ff;
				endcase
			end
		end
	end

	// Execution results; the running operation wins over a software flag write.
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			flags_ff <= `ILS_RST_FLAGS;
			result_ff <= `ILS_RST_WORD;
			program_counter_ff <= `ILS_RST_WORD;
			wrote_ff <= 1'b0;
			branch_ff <= 1'b0;
			o_branch_valid <= 1'b0;
			o_branch_addr <= `ILS_RST_WORD;
		end
		else
		begin
			o_branch_valid <= go_ff & nxt_branch;
			if (go_ff)
			begin
				flags_ff <= nxt_flags;
				result_ff <= nxt_result;
				wrote_ff <= nxt_wrote;
				branch_ff <= nxt_branch;
				if (nxt_branch)
				begin
					program_counter_ff <= {flex[WIDTH-1:1], 1'b0};
					o_branch_addr <= {flex[WIDTH-1:1], 1'b0};
				end
			end
			else if (wr_take && i_avs_address == `ILS_OFF_FLAGS && i_avs_byteenable[0])
			begin
				flags_ff <= i_avs_writedata[3:0];
			end
		end
	end

endmodule // ils_alu

`default_nettype wire

// File: hdl/ils_regs.vh
`ifndef ILS_REGS_VH
`define ILS_REGS_VH

// Register byte offsets, one aligned word each.
`define ILS_OFF_OPA 5'h00
`define ILS_OFF_OPB 5'h04
`define ILS_OFF_SHAMT 5'h08
`define ILS_OFF_CTRL 5'h0c
`define ILS_OFF_FLAGS 5'h10
`define ILS_OFF_RESULT 5'h14
`define ILS_OFF_BRTGT 5'h18
`define ILS_OFF_STATUS 5'h1c

// Control word fields.
`define ILS_CTRL_OP_LSB 0
`define ILS_CTRL_OP_MSB 4
`define ILS_CTRL_SETF 5
`define ILS_CTRL_SHT_LSB 6
`define ILS_CTRL_SHT_MSB 8
`define ILS_CTRL_SHREG 9
`define ILS_CTRL_IMM_LSB 10
`define ILS_CTRL_IMM_MSB 15
`define ILS_CTRL_DPC 16
`define ILS_CTRL_WIDTH 17

// Flag register bit positions.
`define ILS_FLG_V 0
`define ILS_FLG_C 1
`define ILS_FLG_Z 2
`define ILS_FLG_N 3

// Status register bit positions.
`define ILS_STS_BUSY 0
`define ILS_STS_WROTE 1
`define ILS_STS_BRANCH 2

// Reset values.
`define ILS_RST_WORD 32'h0000_0000
`define ILS_RST_CTRL 17'h0_0000
`define ILS_RST_FLAGS 4'h0

// Operation codes.
`define ILS_OP_ADD 5'h00
`define ILS_OP_ADC 5'h01
`define ILS_OP_SUB 5'h02
`define ILS_OP_SBC 5'h03
`define ILS_OP_RSB 5'h04
`define ILS_OP_AND 5'h05
`define ILS_OP_XOR 5'h06
`define ILS_OP_IOR 5'h07
`define ILS_OP_BCLR 5'h08
`define ILS_OP_ORNOT 5'h09
`define ILS_OP_COPY 5'h0a
`define ILS_OP_NCOPY 5'h0b
`define ILS_OP_COMPARE 5'h0c
`define ILS_OP_NCOMPARE 5'h0d
`define ILS_OP_LZC 5'h0e
`define ILS_OP_WIDE 5'h0f

// Shift types.
`define ILS_SH_SHL 3'h0
`define ILS_SH_SHR 3'h1
`define ILS_SH_SAR 3'h2
`define ILS_SH_ROT 3'h3
`define ILS_SH_XROT 3'h4

`endif

// File: hdl/ils_shifter.v
`include "ils_regs.vh"
`default_nettype none

module ils_shifter #(
	parameter WIDTH = 32
) (
	input wire [WIDTH-1:0] i_value, // value to shift
	input wire [2:0] i_type, // shift type
	input wire [7:0] i_amount, // shift amount 0..255
	input wire i_carry, // current carry flag
	output reg [WIDTH-1:0] o_result, // shifted value
	output reg o_carry // carry out
);

	reg [WIDTH:0] t;
	reg [2*WIDTH-1:0] d;
	reg [7:0] cap;

	// Any amount past the width behaves as width plus one, so the cap fits in a byte.
	localparam integer WIDTH_P1 = WIDTH + 1;

	always @*
	begin
		t = {(WIDTH+1){1'b0}};
		d = {2*WIDTH{1'b0}};
		cap = (i_amount > WIDTH) ? WIDTH_P1[7:0] : i_amount;
		o_result = i_value;
		o_carry = i_carry;
		case (i_type)
			`ILS_SH_SHL:
			begin
				t = {i_carry, i_value} << cap;
				o_result = t[WIDTH-1:0];
				o_carry = t[WIDTH];
			end
			`ILS_SH_SHR:
			begin
				t = {i_value, i_carry} >> cap;
				o_result = t[WIDTH:1];
				o_carry = t[0];
			end
			`ILS_SH_SAR:
			begin
				t = $signed({i_value, i_carry}) >>> cap;
				o_result = t[WIDTH:1];
				o_carry = t[0];
			end
			`ILS_SH_ROT:
			begin
				// Only the low bits set the rotation; a multiple of the width leaves the value.
				d = {i_value, i_value} >> i_amount[4:0];
				o_result = d[WIDTH-1:0];
				o_carry = (i_amount == 8'h00) ? i_carry : d[WIDTH-1];
			end
			`ILS_SH_XROT:
			begin
				o_result = {i_carry, i_value[WIDTH-1:1]};
				o_carry = i_value[0];
			end
			default:
			begin
				o_result = i_value;
				o_carry = i_carry;
			end
		endcase
	end

endmodule // ils_shifter

`default_nettype wire

// File: hdl/ils_lzc.v
`default_nettype none

module ils_lzc #(
	parameter WIDTH = 32
) (
	input wire [WIDTH-1:0] i_value, // operand
	output reg [5:0] o_count // leading zeros, WIDTH when all zero
);

	integer i;
	integer n;
	reg found;

	always @*
	begin
		o_count = WIDTH[5:0];
		found = 1'b0;
		n = 0;
		for (i = WIDTH - 1; i >= 0; i = i - 1)
		begin
			if (i_value[i] && !found)
			begin
				n = WIDTH - 1 - i;
				o_count = n[5:0];
				found = 1'b1;
			end
		end
	end

endmodule // ils_lzc

`default_nettype wire

// File: testbench/ils_host.sv
`default_nettype none
module ils_host (
	input wire logic i_clk, // core clock
	input wire logic i_waitrequest, // slave stall
	input wire logic [31:0] i_readdata, // slave read data
	output logic [4:0] o_address, // byte address
	output logic o_read, // read request
	output logic o_write, // write request
	output logic [31:0] o_writedata, // write data
	output logic [3:0] o_byteenable // write lanes
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		o_address = 5'h00;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h0000_0000;
		o_byteenable = 4'h0;
	end
	// A released bus shows the inverse of its last value so that stale data can never pass.
	task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge i_clk);
		o_address <= a;
		o_write <= wr;
		o_read <= !wr;
		o_writedata <= d;
		o_byteenable <= be;
		@(posedge i_clk);
		while (i_waitrequest !== 1'b0)
			@(posedge i_clk);
		q = i_readdata;
		o_read <= 1'b0;
		o_write <= 1'b0;
		o_address <= ~a;
		o_writedata <= ~d;
		o_byteenable <= ~be;
	endtask
endmodule // ils_host
`default_nettype wire

// File: testbench/ils_alu_asserts.sv
`include "ils_regs.vh"
`default_nettype none
module ils_alu_asserts (
	input wire logic i_clk, // core clock
	input wire logic i_rstn, // async reset, active low
	input wire logic [4:0] i_avs_address, // byte address
	input wire logic i_avs_read, // read request
	input wire logic i_avs_write, // write request
	input wire logic [31:0] o_avs_readdata, // read data
	input wire logic o_avs_waitrequest, // stall
	input wire logic o_branch_valid, // branch pulse
	input wire logic [31:0] o_branch_addr // branch target
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	wire logic req;
	assign req = i_avs_read || i_avs_write;
	stall_first_a: assert property (req && !$past(req) |-> o_avs_waitrequest)
		else $error("request answered without a stall cycle");
	stall_bound_a: assert property (req && !$past(req) |-> ##[1:2] !o_avs_waitrequest)
		else $error("request stalled too long");
	idle_ready_a: assert property (!req |-> !o_avs_waitrequest)
		else $error("stall without a request");
	read_hold_a: assert property ($changed(o_avs_readdata) |-> $past(i_avs_read))
		else $error("read data moved without a read");
	branch_even_a: assert property (o_branch_valid |-> !o_branch_addr[0])
		else $error("branch target is odd");
	branch_pulse_a: assert property (o_branch_valid |=> !o_branch_valid)
		else $error("branch pulse longer than one cycle");
	branch_hold_a: assert property ($changed(o_branch_addr) |-> o_branch_valid)
		else $error("branch target moved without a branch");
	branch_cause_a: assert property (o_branch_valid |->
		$past(i_avs_write && !o_avs_waitrequest && i_avs_address == `ILS_OFF_CTRL, 2))
		else $error("branch without a control write");
endmodule // ils_alu_asserts
`default_nettype wire

// File: testbench/ils_tb.sv
`include "ils_regs.vh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk;
	logic i_rstn;
	wire logic [4:0] av_adr;
	wire logic av_rd;
	wire logic av_wr;
	wire logic [31:0] av_wd;
	wire logic [3:0] av_be;
	wire logic [31:0] av_rdata;
	wire logic av_wait;
	wire logic br_valid;
	wire logic [31:0] br_addr;
	integer seed = 32'hf97fbe30;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [31:0] q;
	logic [31:0] res_exp = 32'h0;
	logic [31:0] br_seen = 32'h0;
	logic [31:0] br_exp = 32'h0;
	ils_host host (.i_clk(i_clk), .i_waitrequest(av_wait), .i_readdata(av_rdata),
		.o_address(av_adr), .o_read(av_rd), .o_write(av_wr), .o_writedata(av_wd),
		.o_byteenable(av_be));
	ils_alu dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(av_adr), .i_avs_read(av_rd),
		.i_avs_write(av_wr), .i_avs_writedata(av_wd), .i_avs_byteenable(av_be),
		.o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .o_branch_valid(br_valid),
		.o_branch_addr(br_addr));
	initial
	begin
		i_clk = 1'b0;
		forever
			#10 i_clk = ~i_clk;
	end
	task automatic final_report();
		if (fail_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge i_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			fail_count = fail_count + 1;
			final_report();
		end
	end
	// Counts branch pulses so that a missing or extra one is caught.
	always @(posedge i_clk)
	begin
		if (br_valid === 1'b1)
			br_seen <= br_seen + 32'h1;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			fail_count = fail_count + 1;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, 4'hf, q);
	endtask
	task automatic rd(input logic [4:0] a);
		host.xfer(1'b0, a, 32'h0, 4'hf, q);
	endtask
	// Returns the carry out above the shifted value.
	function automatic logic [32:0] shf(input logic [31:0] b, input logic [2:0] t,
		input logic [7:0] n, input logic c);
		logic [64:0] w;
		logic [31:0] r;
		if (t == `ILS_SH_XROT)
			return {b[0], c, b[31:1]};
		if (n == 8'h00)
			return {c, b};
		w = {33'h0, b} << n;
		if (t == `ILS_SH_SHL)
			return w[32:0];
		if (t == `ILS_SH_SAR)
			w = $signed({b, 33'h0}) >>> n;
		else if (t == `ILS_SH_SHR)
			w = {b, 33'h0} >> n;
		else
		begin
			r = (b >> n[4:0]) | (b << (6'd32 - n[4:0]));
			return {r[31], r};
		end
		return {w[32], w[64:33]};
	endfunction
	// Returns wrote flag, result and the new flags.
	function automatic logic [36:0] model(input logic [4:0] op, input logic sf,
		input logic [32:0] sh, input logic [31:0] a, input logic [31:0] b, input logic [3:0] f);
		logic [32:0] u;
		logic [31:0] x;
		logic [31:0] y;
		logic [31:0] r;
		logic ci;
		logic ar;
		int k;
		x = a;
		y = sh[31:0];
		ci = 1'b0;
		k = 32;
		ar = op <= `ILS_OP_RSB || op == `ILS_OP_COMPARE || op == `ILS_OP_NCOMPARE;
		if (op == `ILS_OP_SUB || op == `ILS_OP_SBC || op == `ILS_OP_COMPARE)
			y = ~y;
		if (op == `ILS_OP_RSB)
		begin
			x = sh[31:0];
			y = ~a;
		end
		if (op == `ILS_OP_ADC || op == `ILS_OP_SBC)
			ci = f[`ILS_FLG_C];
		if (op == `ILS_OP_SUB || op == `ILS_OP_RSB || op == `ILS_OP_COMPARE)
			ci = 1'b1;
		u = {1'b0, x} + {1'b0, y} + ci;
		for (int i = 0; i < 32; i++)
			if (b[i])
				k = 31 - i;
		case (op)
			`ILS_OP_AND: r = a & sh[31:0];
			`ILS_OP_XOR: r = a ^ sh[31:0];
			`ILS_OP_IOR: r = a | sh[31:0];
			`ILS_OP_BCLR: r = a & ~sh[31:0];
			`ILS_OP_ORNOT: r = a | ~sh[31:0];
			`ILS_OP_COPY: r = sh[31:0];
			`ILS_OP_NCOPY: r = ~sh[31:0];
			`ILS_OP_LZC: r = 32'(k);
			`ILS_OP_WIDE: r = {16'h0, b[15:0]};
			default: r = u[31:0];
		endcase
		if (ar && (sf || op >= `ILS_OP_COMPARE))
			f = {u[31], u[31:0] == 32'h0, u[32], x[31] == y[31] && u[31] != x[31]};
		else if (sf && op >= `ILS_OP_AND && op <= `ILS_OP_NCOPY)
			f = {r[31], r == 32'h0, sh[32], f[`ILS_FLG_V]};
		return {op <= `ILS_OP_WIDE && op != `ILS_OP_COMPARE && op != `ILS_OP_NCOMPARE, r, f};
	endfunction
	task automatic run(input logic [4:0] op, input logic sf, input logic [2:0] t,
		input logic sr, input logic [5:0] im, input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] s, input logic [3:0] f, input logic pc);
		logic [32:0] sh;
		logic [36:0] e;
		sh = shf(b, t, sr ? s[7:0] : {2'b00, im}, f[`ILS_FLG_C]);
		e = model(op, sf, sh, a, b, f);
		e[36] = e[36] && !pc;
		if (e[36])
			res_exp = e[35:4];
		wr(`ILS_OFF_OPA, a);
		wr(`ILS_OFF_OPB, b);
		wr(`ILS_OFF_SHAMT, s);
		wr(`ILS_OFF_FLAGS, {28'h0, f});
		wr(`ILS_OFF_CTRL, {15'h0, pc, im, sr, t, sf, op});
		rd(`ILS_OFF_RESULT);
		check(q, res_exp);
		rd(`ILS_OFF_FLAGS);
		check(q, {28'h0, e[3:0]});
		rd(`ILS_OFF_STATUS);
		check(q, {29'h0, pc, e[36], 1'b0});
		rd(`ILS_OFF_OPB);
		check(q, b);
		if (pc)
		begin
			br_exp = br_exp + 32'h1;
			rd(`ILS_OFF_BRTGT);
			check(q, {sh[31:1], 1'b0});
			check(br_addr, {sh[31:1], 1'b0});
		end
		check(br_seen, br_exp);
	endtask
	initial
	begin
		i_rstn = 1'b0;
		repeat (3)
			@(posedge i_clk);
		i_rstn <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			rd(5'(i * 4));
			check(q, 32'h0);
		end
		host.xfer(1'b1, `ILS_OFF_OPA, 32'hffff_ffff, 4'h6, q);
		rd(5'h01);
		check(q, 32'h00ff_ff00);
		wr(`ILS_OFF_RESULT, 32'h1234_5678);
		rd(`ILS_OFF_RESULT);
		check(q, 32'h0);
		run(`ILS_OP_COPY, 1, `ILS_SH_SHL, 0, 6'd31, 0, 32'h3, 0, 4'h0, 0);
		run(`ILS_OP_COPY, 1, `ILS_SH_SHR, 0, 6'd32, 0, 32'h8000_0001, 0, 4'h0, 0);
		run(`ILS_OP_COPY, 1, `ILS_SH_SAR, 0, 6'd32, 0, 32'h8000_0000, 0, 4'h0, 0);
		run(`ILS_OP_NCOPY, 1, `ILS_SH_ROT, 0, 6'd31, 0, 32'h0000_0001, 0, 4'h0, 0);
		run(`ILS_OP_COPY, 1, `ILS_SH_ROT, 0, 6'd0, 0, 32'h0000_0001, 0, 4'h2, 0);
		run(`ILS_OP_COPY, 1, `ILS_SH_XROT, 0, 6'd0, 0, 32'h0000_0001, 0, 4'h2, 0);
		run(`ILS_OP_COPY, 1, `ILS_SH_SHL, 1, 6'd0, 0, 32'h1, 32'h0000_0120, 4'h0, 0);
		run(`ILS_OP_BCLR, 1, `ILS_SH_SHR, 1, 6'd0, 32'hf0f0, 32'h1, 32'h100, 4'h3, 0);
		run(`ILS_OP_LZC, 1, `ILS_SH_SHL, 0, 6'd0, 0, 32'h0, 0, 4'hf, 0);
		run(`ILS_OP_LZC, 0, `ILS_SH_SHL, 0, 6'd0, 0, 32'h8000_0000, 0, 4'h5, 0);
		run(`ILS_OP_COMPARE, 0, `ILS_SH_SHL, 0, 6'd0, 32'h55, 32'h55, 0, 4'h0, 0);
		run(`ILS_OP_NCOMPARE, 0, `ILS_SH_SHL, 0, 6'd0, 32'hffff_ffff, 32'h1, 0, 4'h0, 0);
		run(`ILS_OP_ADD, 1, `ILS_SH_SHL, 0, 6'd0, 32'h7fff_ffff, 32'h1, 0, 4'h0, 0);
		run(`ILS_OP_WIDE, 1, `ILS_SH_SHL, 0, 6'd0, 0, 32'hdead_ffff, 0, 4'h0, 0);
		run(`ILS_OP_COPY, 0, `ILS_SH_SHL, 0, 6'd0, 0, 32'h0000_1235, 0, 4'h9, 1);
		run(5'h10, 1, `ILS_SH_SHL, 0, 6'd0, 32'h1, 32'h2, 0, 4'h6, 0);
		repeat (300)
			run(5'({$random(seed)} % 17), 1'($random(seed)), 3'({$random(seed)} % 5),
				1'($random(seed)), 6'($random(seed)), $random(seed), $random(seed),
				$random(seed), 4'($random(seed)), 1'b0);
		final_report();
	end
endmodule // testbench
bind ils_alu ils_alu_asserts chk (.i_clk(i_clk), .i_rstn(i_rstn),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.o_branch_valid(o_branch_valid), .o_branch_addr(o_branch_addr));
`default_nettype wire
